//--- src/general_timer_prescale_concat.sv
// Purpose: Two-group timer unit with block prescalers and chained timers
// Assumes: AXI4-Lite master keeps one write and one read in flight at most
// Notes:   Counts are TIMER_W bits wide; a chained auxiliary ignores its run bit
`timescale 1ns/100ps
`default_nettype none
module general_timer_prescale_concat
  import gpt_pkg::*;
#(
  parameter int TIMER_W = 16
)(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  output logic [1:0]       bresp_o,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  input  wire logic [7:0]  araddr_i,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             irq_o
);

  typedef struct packed {
    logic [NUM_TIMERS-1:0][TIMER_W-1:0] cnt;
    logic [NUM_TIMERS-1:0][CTRL_W-1:0]  ctrl;
    logic [TIMER_W-1:0]                 capture_reload_register;
    logic [NUM_TIMERS-1:0]              status;
    logic [NUM_TIMERS-1:0]              mask;
    logic [1:0]                         wrap_a;
    logic [1:0]                         wrap_b;
    logic                               aw_rdy;
    logic                               w_rdy;
    logic                               ar_rdy;
    logic                               bvalid;
    logic                               rvalid;
    logic [1:0]                         bresp;
    logic [1:0]                         rresp;
    logic [31:0]                        rdata;
    logic [7:0]                         awaddr;
    logic [31:0]                        wdata;
    logic [3:0]                         wstrb;
    logic                               irq;
  } state_type;

  state_type             s_r;
  state_type             s_nxt;
  logic [NUM_TIMERS-1:0] tick;
  logic [NUM_TIMERS-1:0] wrap_up;
  logic [NUM_TIMERS-1:0] wrap_dn;
  logic [NUM_TIMERS-1:0] cnt_wr;
  logic [NUM_TIMERS-1:0] ctrl_wr;
  logic                  do_wr;

  // Byte-lane merge of write data into an old register image
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        v[8*b +: 8] = data[8*b +: 8];
    return v;
  endfunction

  // Writable control bits per timer slot
  function automatic logic [CTRL_W-1:0] ctrl_mask(input int idx);
    logic [CTRL_W-1:0] m;
    m = CTRL_MASK_AUX;
    if (idx == T_A_CORE)
      m = CTRL_MASK_CORE_A;
    else if (idx == T_B_CORE)
      m = CTRL_MASK_CORE_B;
    return m;
  endfunction

  // One prescaler per timer, block code taken from its group's core control
  for (genvar g = 0; g < NUM_TIMERS; g++)
  begin : gen_pre
    localparam int CORE = (g >= T_B_AUX) ? T_B_CORE : T_A_CORE;
    block_prescaler #(
      .GROUP_B (g >= T_B_AUX)
    ) u_pre (
      .clock_i      (clock_i),
      .reset_i      (reset_i),
      .block_code_i (s_r.ctrl[CORE][CTRL_BPS_LSB +: BPS_W]),
      .ind_code_i   (s_r.ctrl[g][CTRL_DIV_LSB +: DIV_W]),
      .basic_tick_o (),
      .count_tick_o (tick[g])
    );
  end

  // Next state: counting, chaining, bus access, flags
  always_comb
  begin
    logic [31:0] wa;
    logic [31:0] ra;
    logic        up_step;
    logic        dn_step;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rd_val;
    logic [NUM_TIMERS-1:0] w1c;
    wa      = {24'h000000, s_r.awaddr[7:2], 2'h0};
    ra      = {24'h000000, araddr_i[7:2], 2'h0};
    up_step = 1'b0;
    dn_step = 1'b0;
    wr_hit  = 1'b0;
    rd_hit  = 1'b0;
    rd_val  = '0;
    w1c     = '0;
    s_nxt   = s_r;
    wrap_up = '0;
    wrap_dn = '0;
    cnt_wr  = '0;
    ctrl_wr = '0;
    do_wr   = !s_r.aw_rdy && !s_r.w_rdy && !s_r.bvalid;
    // Timer stepping; a chained auxiliary follows its core's wrap pulse
    for (int i = 0; i < NUM_TIMERS; i++)
    begin
      up_step = 1'b0;
      dn_step = 1'b0;
      if (AUX_SET[i] && s_r.ctrl[i][CTRL_LINK])
      begin
        up_step = (i == T_B_AUX) ? s_r.wrap_b[0] : s_r.wrap_a[0];
        dn_step = (i == T_B_AUX) ? s_r.wrap_b[1] : s_r.wrap_a[1];
      end
      else if (s_r.ctrl[i][CTRL_RUN] && tick[i])
      begin
        up_step = !s_r.ctrl[i][CTRL_DOWN];
        dn_step = s_r.ctrl[i][CTRL_DOWN];
      end
      wrap_up[i] = up_step && (s_r.cnt[i] == '1);
      wrap_dn[i] = dn_step && (s_r.cnt[i] == '0);
      if (up_step)
        s_nxt.cnt[i] = s_r.cnt[i] + 1'b1;
      else if (dn_step)
        s_nxt.cnt[i] = s_r.cnt[i] - 1'b1;
    end
    // Core B reloads from the capture/reload register on a wrap
    if ((wrap_up[T_B_CORE] || wrap_dn[T_B_CORE]) && s_r.ctrl[T_B_CORE][CTRL_LINK])
      s_nxt.cnt[T_B_CORE] = s_r.capture_reload_register;
    // Core wraps are passed on one cycle later, well inside two basic cycles
    s_nxt.wrap_a = {wrap_dn[T_A_CORE], wrap_up[T_A_CORE]};
    s_nxt.wrap_b = {wrap_dn[T_B_CORE], wrap_up[T_B_CORE]};
    // Write address and data are taken independently
    if (awvalid_i && s_r.aw_rdy)
    begin
      s_nxt.aw_rdy = 1'b0;
      s_nxt.awaddr = awaddr_i;
    end
    if (wvalid_i && s_r.w_rdy)
    begin
      s_nxt.w_rdy = 1'b0;
      s_nxt.wdata = wdata_i;
      s_nxt.wstrb = wstrb_i;
    end
    // Register write; software wins over stepping on the same count
    if (do_wr)
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        if (wa == 32'(OFF_CTRL + 8'(i * 4)))
        begin
          wr_hit = 1'b1;
          ctrl_wr[i] = 1'b1;
          s_nxt.ctrl[i] = CTRL_W'(wmerge(32'(s_r.ctrl[i]), s_r.wdata, s_r.wstrb)
                                  & 32'(ctrl_mask(i)));
        end
        if (wa == 32'(OFF_COUNT + 8'(i * 4)))
        begin
          wr_hit = 1'b1;
          cnt_wr[i] = 1'b1;
          s_nxt.cnt[i] = TIMER_W'(wmerge(32'(s_r.cnt[i]), s_r.wdata, s_r.wstrb));
        end
      end
      if (wa == 32'(OFF_CAPTURE_RELOAD_REGISTER))
      begin
        wr_hit = 1'b1;
        s_nxt.capture_reload_register = TIMER_W'(wmerge(32'(s_r.capture_reload_register), s_r.wdata, s_r.wstrb));
      end
      if (wa == 32'(OFF_STATUS))
      begin
        wr_hit = 1'b1;
        w1c = NUM_TIMERS'(wmerge(32'h00000000, s_r.wdata, s_r.wstrb));
      end
      if (wa == 32'(OFF_MASK))
      begin
        wr_hit = 1'b1;
        s_nxt.mask = NUM_TIMERS'(wmerge(32'(s_r.mask), s_r.wdata, s_r.wstrb));
      end
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    // Write response taken: reopen both write channels
    if (s_r.bvalid && bready_i)
    begin
      s_nxt.bvalid = 1'b0;
      s_nxt.aw_rdy = 1'b1;
      s_nxt.w_rdy  = 1'b1;
    end
    // Sticky wrap flags; a new wrap beats a clear in the same cycle
    s_nxt.status = (s_r.status & ~w1c) | wrap_up | wrap_dn;
    // Read decode has no side effect on any state
    for (int i = 0; i < NUM_TIMERS; i++)
    begin
      if (ra == 32'(OFF_CTRL + 8'(i * 4)))
      begin
        rd_hit = 1'b1;
        rd_val = 32'(s_r.ctrl[i]);
      end
      if (ra == 32'(OFF_COUNT + 8'(i * 4)))
      begin
        rd_hit = 1'b1;
        rd_val = 32'(s_r.cnt[i]);
      end
    end
    if (ra == 32'(OFF_CAPTURE_RELOAD_REGISTER))
    begin
      rd_hit = 1'b1;
      rd_val = 32'(s_r.capture_reload_register);
    end
    if (ra == 32'(OFF_STATUS))
    begin
      rd_hit = 1'b1;
      rd_val = 32'(s_r.status);
    end
    if (ra == 32'(OFF_MASK))
    begin
      rd_hit = 1'b1;
      rd_val = 32'(s_r.mask);
    end
    if (arvalid_i && s_r.ar_rdy)
    begin
      s_nxt.ar_rdy = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_val;
      s_nxt.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_r.rvalid && rready_i)
    begin
      s_nxt.rvalid = 1'b0;
      s_nxt.ar_rdy = 1'b1;
    end
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
  end

  // State register; control fields, block codes included, clear to zero
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s_r        <= '0;
      s_r.aw_rdy <= 1'b1;
      s_r.w_rdy  <= 1'b1;
      s_r.ar_rdy <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign awready_o = s_r.aw_rdy;
  assign wready_o  = s_r.w_rdy;
  assign bvalid_o  = s_r.bvalid;
  assign bresp_o   = s_r.bresp;
  assign arready_o = s_r.ar_rdy;
  assign rvalid_o  = s_r.rvalid;
  assign rdata_o   = s_r.rdata;
  assign rresp_o   = s_r.rresp;
  assign irq_o     = s_r.irq;

  // Checking helper: block codes untouched since reset
  logic [1:0] bps_touched_r;
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      bps_touched_r <= 2'h0;
    else
      bps_touched_r <= bps_touched_r | {ctrl_wr[T_B_CORE], ctrl_wr[T_A_CORE]};
  end

  bps_reset_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !bps_touched_r[0] |-> (s_r.ctrl[T_A_CORE][CTRL_BPS_LSB +: BPS_W] == BPS_RESET))
    else $error("group A block code left its reset value unprompted");

  bps_reset_b_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !bps_touched_r[1] |-> (s_r.ctrl[T_B_CORE][CTRL_BPS_LSB +: BPS_W] == BPS_RESET))
    else $error("group B block code left its reset value unprompted");

  concat_up_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (s_r.wrap_a[0] && s_r.ctrl[T_A_LOW][CTRL_LINK] && !cnt_wr[T_A_LOW])
      |=> (s_r.cnt[T_A_LOW] == $past(s_r.cnt[T_A_LOW]) + 1'b1))
    else $error("chained high part missed a core overflow");

  concat_down_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (s_r.wrap_b[1] && s_r.ctrl[T_B_AUX][CTRL_LINK] && !cnt_wr[T_B_AUX])
      |=> (s_r.cnt[T_B_AUX] == $past(s_r.cnt[T_B_AUX]) - 1'b1))
    else $error("chained high part missed a core underflow");

  concat_bound_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (wrap_up[T_A_CORE] && s_r.ctrl[T_A_HIGH][CTRL_LINK] && !ctrl_wr[T_A_HIGH])
      |=> s_r.wrap_a[0] ##1
          ($past(cnt_wr[T_A_HIGH]) || (s_r.cnt[T_A_HIGH] == $past(s_r.cnt[T_A_HIGH]) + 1'b1)))
    else $error("core wrap not passed on within the bound");

  status_keep_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !do_wr |=> ((s_r.status & $past(s_r.status)) == $past(s_r.status)))
    else $error("flag cleared without a status write");

  count_hold_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (!s_r.ctrl[T_B_CORE][CTRL_RUN] && !cnt_wr[T_B_CORE])
      |=> (s_r.cnt[T_B_CORE] == $past(s_r.cnt[T_B_CORE])))
    else $error("stopped count changed without a write");

  resp_hold_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (s_r.bvalid && !bready_i) |=> (s_r.bvalid && $stable(s_r.bresp)))
    else $error("write response dropped before acceptance");

endmodule
`default_nettype wire

//--- include/gpt_pkg.sv
// Purpose: Shared constants and helpers for the two-group timer unit
// Assumes: 32-bit AXI4-Lite register port, one system clock
// Notes:   Group A holds timers 0..2, group B holds timers 3..4
package gpt_pkg;

  // Timer slots
  localparam int NUM_TIMERS = 5;
  localparam int T_A_LOW    = 0;
  localparam int T_A_CORE   = 1;
  localparam int T_A_HIGH   = 2;
  localparam int T_B_AUX    = 3;
  localparam int T_B_CORE   = 4;

  // Auxiliary timers, which can be chained to their group's core timer
  localparam logic [NUM_TIMERS-1:0] AUX_SET = 5'h0d;

  // Byte offsets of the register map
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_COUNT  = 8'h14;
  localparam logic [7:0] OFF_CAPTURE_RELOAD_REGISTER = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2c;
  localparam logic [7:0] OFF_MASK   = 8'h30;
  localparam logic [7:0] REG_STRIDE = 8'h04;

  // Control register layout
  localparam int CTRL_W       = 8;
  localparam int CTRL_DIV_LSB = 0;
  localparam int DIV_W        = 3;
  localparam int CTRL_RUN     = 3;
  localparam int CTRL_DOWN    = 4;
  localparam int CTRL_LINK    = 5;
  localparam int CTRL_BPS_LSB = 6;
  localparam int BPS_W        = 2;

  // Writable bits per control register kind
  localparam logic [CTRL_W-1:0] CTRL_MASK_AUX    = 8'h3f;
  localparam logic [CTRL_W-1:0] CTRL_MASK_CORE_A = 8'hdf;
  localparam logic [CTRL_W-1:0] CTRL_MASK_CORE_B = 8'hff;

  // Block prescaler codes
  localparam logic [BPS_W-1:0] BPS_00 = 2'h0;
  localparam logic [BPS_W-1:0] BPS_01 = 2'h1;
  localparam logic [BPS_W-1:0] BPS_10 = 2'h2;
  localparam logic [BPS_W-1:0] BPS_11 = 2'h3;
  localparam logic [BPS_W-1:0] BPS_RESET = BPS_00;

  // System clocks in two basic clock cycles, per group and code
  localparam int TWO_W = 7;
  localparam logic [TWO_W-1:0] TWO_A_01 = 7'h08;
  localparam logic [TWO_W-1:0] TWO_A_00 = 7'h10;
  localparam logic [TWO_W-1:0] TWO_A_11 = 7'h20;
  localparam logic [TWO_W-1:0] TWO_A_10 = 7'h40;
  localparam logic [TWO_W-1:0] TWO_B_01 = 7'h04;
  localparam logic [TWO_W-1:0] TWO_B_00 = 7'h08;
  localparam logic [TWO_W-1:0] TWO_B_11 = 7'h10;
  localparam logic [TWO_W-1:0] TWO_B_10 = 7'h20;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Length of two basic clock cycles in system clocks
  function automatic logic [TWO_W-1:0] two_basic_clocks(input logic       group_b,
                                                         input logic [1:0] code);
    logic [TWO_W-1:0] v;
    v = '0;
    unique case (code)
      BPS_01: v = group_b ? TWO_B_01 : TWO_A_01;
      BPS_00: v = group_b ? TWO_B_00 : TWO_A_00;
      BPS_11: v = group_b ? TWO_B_11 : TWO_A_11;
      BPS_10: v = group_b ? TWO_B_10 : TWO_A_10;
    endcase
    return v;
  endfunction

endpackage

//--- src/block_prescaler.sv
// Purpose: Basic clock and per-timer count tick from block and individual codes
// Assumes: Codes come from registers in the same clock domain
// Notes:   A code change does not restart alignment; the first period after it can be shorter or longer than the new one
`timescale 1ns/100ps
`default_nettype none
module block_prescaler
  import gpt_pkg::*;
#(
  parameter logic GROUP_B = 1'b0
)(
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic [BPS_W-1:0] block_code_i,
  input  wire logic [DIV_W-1:0] ind_code_i,
  output logic                  basic_tick_o,
  output logic                  count_tick_o
);

  typedef struct packed {
    logic [TWO_W-2:0] basic_cnt;
    logic [6:0]       ind_cnt;
    logic             basic_tick;
    logic             count_tick;
  } pre_state_type;

  pre_state_type s_r;
  pre_state_type s_nxt;
  logic [TWO_W-1:0] two_clocks;
  logic [TWO_W-2:0] half;
  logic [6:0]       ind_mask;
  logic             wrap;

  // Basic period is half the two-cycle figure; the divider counts basic ticks
  always_comb
  begin
    s_nxt      = s_r;
    two_clocks = two_basic_clocks(GROUP_B, block_code_i);
    half       = two_clocks[TWO_W-1:1];
    ind_mask   = (7'h01 << ind_code_i) - 7'h01;
    wrap       = (s_r.basic_cnt >= (half - 6'h01));
    s_nxt.basic_cnt  = wrap ? '0 : s_r.basic_cnt + 6'h01;
    s_nxt.basic_tick = wrap;
    s_nxt.ind_cnt    = wrap ? s_r.ind_cnt + 7'h01 : s_r.ind_cnt;
    s_nxt.count_tick = wrap && ((s_r.ind_cnt & ind_mask) == ind_mask);
  end

  // State register
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign basic_tick_o = s_r.basic_tick;
  assign count_tick_o = s_r.count_tick;

  // Checking helpers: gaps between ticks and code stability
  logic [12:0] bgap_r;
  logic [12:0] cgap_r;
  logic [4:0]  codes_r;
  logic        bsettled_r;
  logic        csettled_r;
  logic        changed;
  logic [12:0] expected;

  assign changed  = ({block_code_i, ind_code_i} != codes_r);
  assign expected = 13'(half) << ind_code_i;

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bgap_r     <= '0;
      cgap_r     <= '0;
      codes_r    <= '0;
      bsettled_r <= 1'b0;
      csettled_r <= 1'b0;
    end
    else
    begin
      codes_r    <= {block_code_i, ind_code_i};
      bgap_r     <= basic_tick_o ? 13'h0001 : bgap_r + 13'h0001;
      cgap_r     <= count_tick_o ? 13'h0001 : cgap_r + 13'h0001;
      bsettled_r <= changed ? 1'b0 : (basic_tick_o ? 1'b1 : bsettled_r);
      csettled_r <= changed ? 1'b0 : (count_tick_o ? 1'b1 : csettled_r);
    end
  end

  basic_period_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (basic_tick_o && bsettled_r && !changed) |-> (bgap_r == 13'(half)))
    else $error("basic tick period differs from the code table");

  count_period_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (count_tick_o && csettled_r && !changed) |-> (cgap_r == expected))
    else $error("count tick period is not block times individual divider");

  tick_aligned_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    count_tick_o |-> basic_tick_o)
    else $error("count tick outside a basic tick");

endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the two-group timer unit
// Assumes: Registers reached only over AXI4-Lite, one system clock
// Notes:   Prescaler rates are judged by counts seen over fixed windows
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import gpt_pkg::*;
;
  logic        clock_i;
  logic        reset_i;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [1:0]  last_bresp;
  logic [31:0] rdata;
  int          bad_count;
  int          cmp_count;

  general_timer_prescale_concat uut (
    .clock_i(clock_i), .reset_i(reset_i),
    .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
    .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata), .wstrb_i(wstrb),
    .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
    .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr),
    .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp),
    .irq_o(irq)
  );

  // System clock, 8 ns period
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // An unknown value seen fails too, since ok then stays unknown
  task automatic check_range(input string what, input logic [31:0] seen, input int lo,
                             input int hi);
    logic ok;
    ok = (seen >= lo) && (seen <= hi);
    check(what, {31'h0, ok}, 32'h1);
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    int   n;
    @(posedge clock_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_done = 1'b0;
    w_done  = 1'b0;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clock_i);
      if (aw_done && w_done && bvalid)
      begin
        last_bresp = bresp;
        bready <= 1'b0;
        break;
      end
      if (!aw_done && awready)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    if (n == 50)
    begin
      check("write handshake", 32'h0, 32'h1);
      final_report();
    end
  endtask

  task automatic rd_resp(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic a_done;
    int   n;
    @(posedge clock_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    a_done  = 1'b0;
    d       = 'x;
    r       = 'x;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clock_i);
      if (a_done && rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (!a_done && arready)
      begin
        a_done = 1'b1;
        arvalid <= 1'b0;
      end
    end
    if (n == 50)
    begin
      check("read handshake", 32'h0, 32'h1);
      final_report();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    rd_resp(a, d, r);
  endtask

  // Basic clock period in system clocks, half of the two-cycle table
  function automatic int basic_period(input logic grp_b, input logic [1:0] code);
    int two;
    case (code)
      2'h1:    two = 8;
      2'h0:    two = 16;
      2'h3:    two = 32;
      default: two = 64;
    endcase
    return grp_b ? two / 4 : two / 2;
  endfunction

  function automatic logic [7:0] ctrl_mask(input int idx);
    return (idx == 1) ? CTRL_MASK_CORE_A : (idx == 4) ? CTRL_MASK_CORE_B : CTRL_MASK_AUX;
  endfunction

  // Main sequence
  initial
  begin : main
    logic [31:0] v, hi0, hi1, lo;
    logic [1:0]  r, c;
    logic        g;
    int          k, p, idx;
    awvalid   = 1'b0;
    wvalid    = 1'b0;
    bready    = 1'b0;
    arvalid   = 1'b0;
    rready    = 1'b0;
    awaddr    = 8'h00;
    araddr    = 8'h00;
    wdata     = 32'h0;
    wstrb     = 4'hf;
    reset_i   = 1'b1;
    bad_count = 0;
    cmp_count = 0;
    void'($urandom(32'hd34f));
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    for (k = 0; k < 5; k++)
    begin
      rd(8'(4 * k), v);
      check("control after reset", v, 32'h0);
    end
    rd_resp(8'h34, v, r);
    check("unmapped read", {v[29:0], r}, {30'h0, RESP_SLVERR});
    wr(8'h34, 32'h5);
    check("unmapped write resp", {30'h0, last_bresp}, {30'h0, RESP_SLVERR});
    // Every block code of both groups, individual divider 1
    for (k = 0; k < 8; k++)
    begin
      c   = 2'(k % 4);
      g   = (k >= 4);
      idx = g ? 4 : 1;
      p   = basic_period(g, c);
      wr(8'(4 * idx), {24'h0, c, 6'h00});
      wr(8'h14 + 8'(4 * idx), 32'h0);
      wr(8'(4 * idx), {24'h0, c, 6'h08});
      repeat (16 * p) @(posedge clock_i);
      rd(8'h14 + 8'(4 * idx), v);
      check_range("basic rate", v, 15, 17 + 8 / p);
      wr(8'(4 * idx), {24'h0, c, 6'h00});
    end
    // Group B code 00 with divider 111 counts once per 512 clocks
    wr(8'h24, 32'h0);
    wr(8'h10, 32'h0f);
    repeat (3 * 512) @(posedge clock_i);
    rd(8'h24, v);
    check_range("joint divider rate", v, 2, 4);
    // Chained pair across a core overflow, read high-low-wait-high
    wr(8'h10, 32'h40);
    wr(8'h0c, 32'h20);
    wr(8'h20, 32'h5);
    wr(8'h24, 32'hfff0);
    wr(8'h10, 32'h48);
    for (k = 0; k < 6; k++)
    begin
      repeat ($urandom_range(15)) @(posedge clock_i);
      rd(8'h20, hi0);
      rd(8'h24, lo);
      repeat (2 * basic_period(1'b1, 2'h1)) @(posedge clock_i);
      rd(8'h20, hi1);
      if (hi1 !== hi0)
        rd(8'h24, lo);
      check("chained pair", {31'h0, (hi1 === 32'h5 && lo >= 32'hfff0) ||
            (hi1 === 32'h6 && lo < 32'h100)}, 32'h1);
    end
    wr(8'h10, 32'h40);
    rd(8'h20, v);
    check("aux after overflow", v, 32'h6);
    wr(8'h24, 32'h1234);
    rd(8'h24, v);
    rd(8'h24, lo);
    check("count reread", lo, 32'h1234);
    // Count down through zero, auxiliary must step down
    wr(8'h24, 32'h2);
    wr(8'h10, 32'h58);
    repeat (40) @(posedge clock_i);
    wr(8'h10, 32'h40);
    rd(8'h20, v);
    check("aux after underflow", v, 32'h5);
    // Group A chain: both auxiliaries step once when the core overflows
    wr(8'h00, 32'h20);
    wr(8'h08, 32'h20);
    wr(8'h14, 32'h7);
    wr(8'h1c, 32'h3);
    wr(8'h18, 32'hfff8);
    wr(8'h04, 32'h48);
    repeat (100) @(posedge clock_i);
    wr(8'h04, 32'h40);
    rd(8'h14, v);
    check("low aux after overflow", v, 32'h8);
    rd(8'h1c, v);
    check("high aux after overflow", v, 32'h4);
    rd(8'h18, v);
    check_range("core A after overflow", v, 17, 19);
    // Wrap flag, masking and write-one-to-clear
    wr(8'h30, 32'h0);
    repeat (3) @(posedge clock_i);
    check("irq masked", {31'h0, irq}, 32'h0);
    rd(8'h2c, v);
    rd(8'h2c, v);
    check("wrap flag", v & 32'h10, 32'h10);
    wr(8'h30, 32'h10);
    repeat (3) @(posedge clock_i);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(8'h2c, 32'h10);
    repeat (3) @(posedge clock_i);
    check("irq cleared", {31'h0, irq}, 32'h0);
    // Random control words, writable bits only
    for (k = 0; k < 12; k++)
    begin
      idx = $urandom_range(4);
      v   = $urandom;
      wr(8'(4 * idx), v);
      check("control write resp", {30'h0, last_bresp}, {30'h0, RESP_OKAY});
      rd(8'(4 * idx), lo);
      check("control readback", lo, v & {24'h0, ctrl_mask(idx)});
    end
    final_report();
  end
endmodule
`default_nettype wire
